/* File: dsw_dev.sv */
// Converter end: shift in words and load channel and control latches
`timescale 1ns/1ps
module dsw_dev (
    // Power-on reset
    input wire logic por_n,
    // Serial link
    dsw_link_if.dev link,
    // Converter latches
    output logic [dsw_pkg::CODE_BITS-1:0] dac_a_code,
    output logic [dsw_pkg::CODE_BITS-1:0] dac_b_code,
    output logic [dsw_pkg::CODE_BITS-1:0] staging_code,
    output logic speed_select,
    output logic power_down_flag,
    // Latch event, one serial clock period
    output logic load_strobe
);
    import dsw_pkg::*;

    // ------------------------------------------------------------
    // Serial capture
    // ------------------------------------------------------------
    logic [WORD_BITS-1:0] word;
    logic [CNT_W-1:0] count;
    logic fresh;

    // Frame starts only on a low select, so the counter relies on it
    dsw_shift #(
        .WIDTH(WORD_BITS)
    ) u_shift (
        .sclk(link.sclk),
        .rst_n(por_n),
        .cs_n(link.cs_n),
        .din(link.din),
        .word(word),
        .count(count),
        .fresh(fresh)
    );

    // ------------------------------------------------------------
    // Short frame capture on the rising select edge
    // ------------------------------------------------------------
    logic [WORD_BITS-1:0] short_word_reg;
    logic short_tog_reg;
    logic short_meta_reg;
    logic short_sync_reg;
    logic short_seen_reg;

    // A frame cut short still moves the shift contents on select rise
    always_ff @(posedge link.cs_n or negedge por_n) begin
        if (!por_n) begin
            short_word_reg <= WORD_RST;
            short_tog_reg <= 1'b0;
        end else if (count != CNT_FULL && count != '0 && !fresh) begin
            short_word_reg <= word;
            short_tog_reg <= ~short_tog_reg;
        end
    end

    // Bring the short frame event into the rising serial clock domain
    always_ff @(posedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            short_meta_reg <= 1'b0;
            short_sync_reg <= 1'b0;
        end else begin
            short_meta_reg <= short_tog_reg;
            short_sync_reg <= short_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Load decision on the rising serial clock
    // ------------------------------------------------------------
    logic done_reg;
    logic full_load;
    logic short_load;
    logic do_load;
    logic [WORD_BITS-1:0] load_word;

    // Full word: count has just reached sixteen and is not yet used
    assign full_load = !link.cs_n && count == CNT_FULL && !done_reg;

    // Short frame waits for a synchronised toggle
    assign short_load = short_sync_reg != short_seen_reg;

    // A full word in the same edge is the newer data and wins
    assign do_load = full_load || short_load;
    assign load_word = full_load ? word : short_word_reg;

    // Remember that this frame's word has been latched
    always_ff @(posedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            done_reg <= 1'b0;
        end else if (count != CNT_FULL) begin
            done_reg <= 1'b0;
        end else if (full_load) begin
            done_reg <= 1'b1;
        end
    end

    // Retire the short frame event once seen
    always_ff @(posedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            short_seen_reg <= 1'b0;
        end else begin
            short_seen_reg <= short_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    dsw_sel_e sel;
    logic [CODE_BITS-1:0] new_code;

    // Select is formed from the top and fourth bits of the word
    always_comb begin
        sel = dsw_sel_e'({load_word[SEL_HI_POS],
                          load_word[SEL_LO_POS]});
    end

    // Low twelve bits are the unsigned code, MSB at bit eleven
    assign new_code = load_word[CODE_BITS-1:0];

    // ------------------------------------------------------------
    // Control latch
    // ------------------------------------------------------------

    // Speed and power-down follow every loaded word
    always_ff @(posedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            speed_select <= SPEED_RST;
            power_down_flag <= PDN_RST;
        end else if (do_load) begin
            speed_select <= load_word[SPEED_POS];
            power_down_flag <= load_word[PDN_POS];
        end
    end

    // ------------------------------------------------------------
    // Code latches
    // ------------------------------------------------------------

    // Channel A takes the code only on an A write
    always_ff @(posedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            dac_a_code <= CODE_RST;
        end else if (do_load && sel == DSW_SEL_A_XFER) begin
            dac_a_code <= new_code;
        end
    end

    // Channel B takes new code, or staging content on an A write
    always_ff @(posedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            dac_b_code <= CODE_RST;
        end else if (do_load) begin
            unique case (sel)
                DSW_SEL_B_BUF: begin
                    dac_b_code <= new_code;
                end
                DSW_SEL_A_XFER: begin
                    dac_b_code <= staging_code;
                end
                DSW_SEL_BUF: begin
                    dac_b_code <= dac_b_code;
                end
                DSW_SEL_RSVD: begin
                    dac_b_code <= dac_b_code;
                end
            endcase
        end
    end

    // Staging latch is written by B writes and staging-only writes
    always_ff @(posedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            staging_code <= CODE_RST;
        end else if (do_load) begin
            unique case (sel)
                DSW_SEL_B_BUF: begin
                    staging_code <= new_code;
                end
                DSW_SEL_BUF: begin
                    staging_code <= new_code;
                end
                DSW_SEL_A_XFER: begin
                    staging_code <= staging_code;
                end
                DSW_SEL_RSVD: begin
                    staging_code <= staging_code;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Load indication
    // ------------------------------------------------------------

    // High for the serial clock period after each latch update
    always_ff @(posedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            load_strobe <= 1'b0;
        end else begin
            load_strobe <= do_load;
        end
    end

endmodule

/* File: dsw_pkg.sv */
// Shared constants and types for the dual converter serial word loader
package dsw_pkg;

    // ------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int BYTE_BITS = 8;
    localparam int SEL_HI_POS = 15;
    localparam int SPEED_POS = 14;
    localparam int PDN_POS = 13;
    localparam int SEL_LO_POS = 12;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_FULL = 5'h10;

    // Register select codes, select_high then select_low
    typedef enum logic [1:0] {
        DSW_SEL_B_BUF,
        DSW_SEL_BUF,
        DSW_SEL_A_XFER,
        DSW_SEL_RSVD
    } dsw_sel_e;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [11:0] CODE_RST = 12'h000;
    localparam logic SPEED_RST = 1'b0;
    localparam logic PDN_RST = 1'b0;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ------------------------------------------------------------
    // Controller registers on APB
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam int BUSY_POS = 0;
    localparam int BYTE_MODE_POS = 0;

    // ------------------------------------------------------------
    // Serial clock timing
    // ------------------------------------------------------------
    localparam longint PCLK_HZ = 10_000_000;
    localparam longint SCLK_MAX_HZ = 20_000_000;
    localparam longint HALF_CALC =
        (PCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam int SCLK_HALF_CYC = (HALF_CALC < 1) ? 1 : int'(HALF_CALC);

    // Controller sequencer states
    typedef enum logic [2:0] {
        DSW_IDLE,
        DSW_SETUP,
        DSW_RISE,
        DSW_FALL,
        DSW_GAP,
        DSW_TAIL_H,
        DSW_TAIL_L,
        DSW_CS_HIGH
    } dsw_state_e;

endpackage

/* File: dsw_link_if.sv */
// Three-wire serial link between controller and converter
`timescale 1ns/1ps
interface dsw_link_if;
    logic cs_n;
    logic sclk;
    logic din;

    // Converter end listens on all three wires
    modport dev (
        input cs_n,
        input sclk,
        input din
    );

    // Controller end drives all three wires
    modport host (
        output cs_n,
        output sclk,
        output din
    );
endinterface

/* File: dsw_shift.sv */
// Serial input shift register and bit counter on falling serial clock
`timescale 1ns/1ps
module dsw_shift #(
    parameter int WIDTH = dsw_pkg::WORD_BITS
) (
    // Link side
    input wire logic sclk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic din,
    // Captured word
    output logic [WIDTH-1:0] word,
    output logic [dsw_pkg::CNT_W-1:0] count,
    output logic fresh
);
    import dsw_pkg::*;

    // Marks the first falling edge of a frame; set while select is high
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // Shift in MSB first on each falling edge while selected, until sixteen bits are in
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            word <= WORD_RST;
        end else if (!cs_n && count != CNT_FULL) begin
            word <= {word[WIDTH-2:0], din};
        end else if (!cs_n && fresh) begin
            word <= {word[WIDTH-2:0], din};
        end
    end

    // Bits of the current frame; stays at full once the word is in
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!cs_n && fresh) begin
            count <= 5'h01;
        end else if (!cs_n && count != CNT_FULL) begin
            count <= count + 5'h01;
        end
    end
endmodule

/* File: dsw_host.sv */
// Controller end: APB registers and serial word sender with divider
`timescale 1ns/1ps
module dsw_host #(
    parameter int HALF_CYC = dsw_pkg::SCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    dsw_link_if.host link
);
    import dsw_pkg::*;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    dsw_state_e state;
    logic byte_mode_reg;
    logic [WORD_BITS-1:0] data_reg;
    logic busy;
    logic setup_ph;
    logic access_ph;
    logic mapped;
    logic send_req;

    assign busy = state != DSW_IDLE;
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign mapped = paddr == OFF_DATA || paddr == OFF_STATUS ||
                    paddr == OFF_CFG;
    assign pready = 1'b1;

    // Unmapped address, or a word pushed while sending, is an error
    assign pslverr = access_ph &&
        (!mapped || (pwrite && paddr == OFF_DATA && busy));
    assign send_req = access_ph && pwrite && paddr == OFF_DATA && !busy;

    // Word to send and byte mode setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg <= WORD_RST;
            byte_mode_reg <= 1'b0;
        end else if (access_ph && pwrite) begin
            if (send_req) begin
                data_reg <= pwdata[WORD_BITS-1:0];
            end
            if (paddr == OFF_CFG) begin
                byte_mode_reg <= pwdata[BYTE_MODE_POS];
            end
        end
    end

    // Read data prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_ph) begin
            prdata <= '0;
            if (paddr == OFF_DATA) begin
                prdata[WORD_BITS-1:0] <= data_reg;
            end
            if (paddr == OFF_STATUS) begin
                prdata[BUSY_POS] <= busy;
            end
            if (paddr == OFF_CFG) begin
                prdata[BYTE_MODE_POS] <= byte_mode_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial clock divider
    // ------------------------------------------------------------
    logic [15:0] div_cnt;
    logic tick;

    // Each half serial period lasts HALF_CYC bus clocks
    assign tick = div_cnt == 16'(HALF_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
        end else if (!busy || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Sender sequence
    // ------------------------------------------------------------
    logic [WORD_BITS-1:0] shreg;
    logic [CNT_W-1:0] bit_cnt;

    // Select low, then per bit rise with data and fall to sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DSW_IDLE;
            shreg <= WORD_RST;
            bit_cnt <= '0;
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            link.din <= 1'b0;
        end else if (state == DSW_IDLE) begin
            if (send_req) begin
                shreg <= pwdata[WORD_BITS-1:0];
                bit_cnt <= '0;
                link.cs_n <= 1'b0;
                state <= DSW_SETUP;
            end
        end else if (tick) begin
            unique case (state)
                DSW_GAP: begin
                    // Extra low half period between the two bytes
                    state <= DSW_RISE;
                end
                DSW_SETUP: begin
                    link.sclk <= 1'b1;
                    link.din <= shreg[WORD_BITS-1];
                    shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                    state <= DSW_FALL;
                end
                DSW_RISE: begin
                    link.sclk <= 1'b1;
                    link.din <= shreg[WORD_BITS-1];
                    shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                    state <= DSW_FALL;
                end
                DSW_FALL: begin
                    link.sclk <= 1'b0;
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'(WORD_BITS - 1)) begin
                        state <= DSW_TAIL_H;
                    end else if (byte_mode_reg &&
                                 bit_cnt == 5'(BYTE_BITS - 1)) begin
                        state <= DSW_GAP;
                    end else begin
                        state <= DSW_RISE;
                    end
                end
                DSW_TAIL_H: begin
                    link.sclk <= 1'b1;
                    state <= DSW_TAIL_L;
                end
                DSW_TAIL_L: begin
                    link.sclk <= 1'b0;
                    state <= DSW_CS_HIGH;
                end
                DSW_CS_HIGH: begin
                    link.cs_n <= 1'b1;
                    state <= DSW_IDLE;
                end
                default: begin
                    state <= DSW_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: dsw_link_monitor.sv */
// Assertion checker for the serial link and the converter latches
`timescale 1ns/1ps
module dsw_link_monitor (
    // Link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    // Converter end
    input wire logic por_n,
    input wire logic [dsw_pkg::CODE_BITS-1:0] dac_a_code,
    input wire logic [dsw_pkg::CODE_BITS-1:0] dac_b_code,
    input wire logic [dsw_pkg::CODE_BITS-1:0] staging_code,
    input wire logic speed_select,
    input wire logic power_down_flag,
    input wire logic load_strobe
);
    import dsw_pkg::*;
    logic [4:0] fall_cnt;
    logic [15:0] word_sh;
    logic [11:0] old_a, old_b, old_s;
    logic [1:0] sel;
    logic at_load;
    assign sel = {word_sh[SEL_HI_POS], word_sh[SEL_LO_POS]};
    assign at_load = (fall_cnt == 5'h10);

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Falling edges within the frame, cleared while deselected
    always_ff @(negedge sclk or posedge cs_n or negedge por_n) begin
        if (!por_n) begin
            fall_cnt <= 5'h00;
        end else if (cs_n) begin
            fall_cnt <= 5'h00;
        end else if (fall_cnt != 5'h1F) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end
    // Word as sampled, plus latch contents just before the load
    always_ff @(negedge sclk or negedge por_n) begin
        if (!por_n) begin
            word_sh <= 16'h0000;
            old_a <= 12'h000;
            old_b <= 12'h000;
            old_s <= 12'h000;
        end else if (!cs_n && fall_cnt < 5'h10) begin
            word_sh <= {word_sh[14:0], din};
            old_a <= dac_a_code;
            old_b <= dac_b_code;
            old_s <= staging_code;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(negedge sclk); endclocking
    default disable iff (!por_n);

    chk_sclk_gate: assert property (@(posedge sclk)
        !cs_n) else $error("serial clock rose while deselected");
    chk_frame_len: assert property (@(posedge cs_n)
        fall_cnt == 5'h11) else $error("frame length wrong");
    chk_strobe_load: assert property (at_load |-> load_strobe)
        else $error("no load after sixteenth bit");
    chk_strobe_quiet: assert property (
        fall_cnt inside {[1:15]} |-> !load_strobe)
        else $error("load before word complete");
    chk_a_write: assert property (
        at_load && sel == 2'b10 |-> dac_a_code == word_sh[11:0])
        else $error("channel A code wrong");
    chk_b_xfer: assert property (
        at_load && sel == 2'b10 |-> dac_b_code == old_s)
        else $error("channel B not moved from staging");
    chk_b_write: assert property (at_load && sel == 2'b00 |->
        dac_b_code == word_sh[11:0] && staging_code == word_sh[11:0]
        && dac_a_code == old_a) else $error("channel B write wrong");
    chk_buf_only: assert property (at_load && sel == 2'b01 |->
        staging_code == word_sh[11:0] && dac_a_code == old_a
        && dac_b_code == old_b) else $error("staging write wrong");
    chk_rsvd_hold: assert property (at_load && sel == 2'b11 |->
        dac_a_code == old_a && dac_b_code == old_b
        && staging_code == old_s) else $error("reserved code changed latch");
    chk_ctrl_bits: assert property (at_load |->
        speed_select == word_sh[14] && power_down_flag == word_sh[13])
        else $error("speed or power-down bit wrong");
    chk_code_hold: assert property (
        fall_cnt inside {[2:15]} |-> $stable(dac_a_code)
        && $stable(dac_b_code)) else $error("code changed mid-word");

    // Main scenarios reached
    cov_both: cover property (at_load && sel == 2'b10);
    cov_rsvd: cover property (at_load && sel == 2'b11);
    cov_pdn: cover property ($rose(power_down_flag));
endmodule

/* File: tb.sv */
// Self-checking bench: APB controller feeding the converter end
`timescale 1ns/1ps
module tb;
    import dsw_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic por_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] dac_a_code, dac_b_code, staging_code;
    logic speed_select, power_down_flag, load_strobe;
    int errors = 0;
    int n_tests = 0;
    int seed = 1880;
    int n_fall = 0;
    logic [37:0] exp_q[$];
    logic [15:0] word_q[$];
    logic [16:0] cap = 17'h00000;
    logic [11:0] ea = 12'h000, eb = 12'h000, es = 12'h000;
    logic espd = 1'b0, epdn = 1'b0;
    logic [31:0] rd;
    logic err;
    logic [15:0] w;

    dsw_link_if link ();
    dsw_host dsw_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    dsw_dev dsw_dev_i (.por_n(por_n), .link(link),
        .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
        .staging_code(staging_code), .speed_select(speed_select),
        .power_down_flag(power_down_flag), .load_strobe(load_strobe));
    dsw_link_monitor dsw_link_monitor_i (.cs_n(link.cs_n),
        .sclk(link.sclk), .din(link.din), .por_n(por_n),
        .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
        .staging_code(staging_code), .speed_select(speed_select),
        .power_down_flag(power_down_flag), .load_strobe(load_strobe));

    // Bus clock, 100 ns period
    always #50 pclk = ~pclk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [47:0] got, input logic [47:0] want,
                         input string what);
        n_tests++;
        if (got !== want) begin
            errors++;
            $display("[ERR] %0t %s: got %0h want %0h", $time, what, got,
                     want);
        end
    endtask

    // One APB transfer; answer taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_idle();
        rd = 32'h00000001;
        while (rd[BUSY_POS] !== 1'b0) apb(1'b0, OFF_STATUS, 32'h0);
    endtask

    // Start a word and note the latch contents expected after it
    task automatic send(input logic [15:0] v, input logic idle);
        apb(1'b1, OFF_DATA, {16'h0000, v});
        check(err, 1'b0, "data write");
        case (dsw_sel_e'({v[SEL_HI_POS], v[SEL_LO_POS]}))
            DSW_SEL_B_BUF: begin
                eb = v[11:0];
                es = v[11:0];
            end
            DSW_SEL_BUF: es = v[11:0];
            DSW_SEL_A_XFER: begin
                ea = v[11:0];
                eb = es;
            end
            default: ;
        endcase
        espd = v[SPEED_POS];
        epdn = v[PDN_POS];
        exp_q.push_back({ea, eb, es, espd, epdn});
        word_q.push_back(v);
        if (idle) wait_idle();
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Observers
    // ------------------------------------------------------------
    // Collect bits on the edge where the converter samples them
    always @(negedge link.sclk) begin
        if (link.cs_n === 1'b0) begin
            cap = {cap[15:0], link.din};
            n_fall++;
        end
    end
    // At frame end compare wire and latches with the oldest note
    always @(posedge link.cs_n) begin
        if (word_q.size() > 0) begin
            check(cap[16:1], word_q.pop_front(), "wire word");
            check(n_fall, 17, "falling edges");
            check({dac_a_code, dac_b_code, staging_code, speed_select,
                power_down_flag}, exp_q.pop_front(), "latches");
        end
        cap = 17'h00000;
        n_fall = 0;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        check({dac_a_code, dac_b_code, staging_code, speed_select,
            power_down_flag}, 38'h0, "reset latches");
        check({link.cs_n, link.sclk}, 2'b10, "idle link");
        apb(1'b0, OFF_CFG, 32'h0);
        check(rd, 32'h0, "config reset");
        $display("test reset done");
        // Every select code with random speed, power-down and code
        for (int i = 0; i < 12; i++) begin
            w = 16'($random(seed));
            w[SEL_HI_POS] = i[1];
            w[SEL_LO_POS] = i[0];
            if (i == 8) w[11:0] = 12'hFFF;
            if (i == 9) w[11:0] = 12'h000;
            send(w, 1'b1);
        end
        apb(1'b0, OFF_DATA, 32'h0);
        check(rd[15:0], w, "data readback");
        $display("test decode done");
        // Word sent as two bytes
        apb(1'b1, OFF_CFG, 32'h00000001);
        send(16'($random(seed)) & 16'hEFFF, 1'b1);
        send(16'h8ABC, 1'b1);
        apb(1'b1, OFF_CFG, 32'h0);
        $display("test byte mode done");
        // Unmapped address and a write while busy are refused
        apb(1'b0, 8'h0C, 32'h0);
        check({err, rd}, {1'b1, 32'h0}, "unmapped read");
        send(16'h0123, 1'b0);
        apb(1'b1, OFF_DATA, 32'h0000C456);
        check(err, 1'b1, "write while busy");
        wait_idle();
        check(exp_q.size(), 0, "frames missing");
        $display("test refusals done");
        complete_run();
    end

    // Watchdog against a hung transfer
    initial begin
        #2000000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule
